//--- common/port_cfg_pkg.sv
// Constants for the port identification and command register block
package port_cfg_pkg;
  localparam logic [7:0]  OFS_IDENT      = 8'h00;
  localparam logic [7:0]  OFS_COMMAND    = 8'h04;
  localparam logic [15:0] MAKER_ID_DFLT  = 16'h1a2b; // Arbitrary value
  localparam logic [15:0] PART_ID_DFLT   = 16'h3c4d; // Arbitrary value
  localparam int          CMD_IO_BIT     = 0;
  localparam int          CMD_MEM_BIT    = 1;
  localparam int          CMD_FWD_BIT    = 2;
  localparam int          CMD_PERR_BIT   = 6;
  localparam int          CMD_ERR_BIT    = 8;
  localparam int          CMD_INTD_BIT   = 10;
  localparam logic [15:0] CMD_WR_MASK    = 16'h0547;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam int          STS_SSE_BIT    = 30;
  typedef enum logic [1:0] {REQ_NONE, REQ_TAKE, REQ_UR} req_verdict_t;
endpackage

//--- rtl/port_id_store.sv
// Identification store with override loading
`timescale 1ns/1ns
`default_nettype none
module port_id_store
  import port_cfg_pkg::*;
#(
  parameter logic [15:0] DFLT = 16'h0000
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Override load
  input  wire logic        load_en,
  input  wire logic [15:0] load_val,
  // Value seen by software
  output logic      [15:0] id_ff
);
  // Default at reset, replaced by SMBus or EEPROM load only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      id_ff <= DFLT;
    end else if (load_en) begin
      id_ff <= load_val;
    end
  end
endmodule
`default_nettype wire

//--- rtl/port_cmd_regs.sv
// Identification and command registers for one switch port
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Maker identification read-only in bits 15:0 of word 0.
// - Part identification in bits 31:16; both loadable by SMBus or EEPROM.
// - Command bit 0 enables I/O responses; resets to zero.
// - Command bit 1 enables memory responses; resets to zero.
// - Bit 2 clear blocks upstream requests; downstream requests become unsupported.
// - Rejected non-posted request gets unsupported-request completion.
// - Bit 2 set forwards memory and I/O requests upstream.
// - Bits 3,4,5,7,9 read zero and ignore writes.
// - Bit 6 set enables normal parity-error action; resets zero.
// - Bit 8 gates fatal and non-fatal error reporting; resets zero.
// - Bit 10 stops own INTx, not forwarded INTx; resets zero.
// - Signaled-system-error set on error message sent while bit 8 set.
module port_cmd_regs
  import port_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Configuration access
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [3:0]  cfg_be,
  output logic      [31:0] cfg_rdata,
  // Identification override from SMBus or EEPROM
  input  wire logic        maker_load,
  input  wire logic [15:0] maker_val,
  input  wire logic        part_load,
  input  wire logic [15:0] part_val,
  // Primary side requests
  input  wire logic        pri_io_req,
  input  wire logic        pri_mem_req,
  output logic             pri_io_accept,
  output logic             pri_mem_accept,
  // Downstream side requests bound upstream
  input  wire logic        dn_req,
  input  wire logic        dn_nonposted,
  output logic             up_fwd,
  output logic             dn_ur,
  output logic             ur_cpl,
  // Errors and interrupts
  input  wire logic        parity_err,
  output logic             parity_act,
  input  wire logic        err_detect,
  output logic             err_msg,
  input  wire logic        sse_clear,
  output logic             sse_ff,
  input  wire logic        own_intx,
  input  wire logic        fwd_intx,
  output logic             intx_msg,
  // Decoded verdict for the downstream request
  output req_verdict_t     dn_verdict
);
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;
  logic [15:0] maker_id;
  logic [15:0] part_id;
  logic [15:0] wr_data;

  port_id_store #(.DFLT(MAKER_ID_DFLT)) u_maker (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .load_en  (maker_load),
    .load_val (maker_val),
    .id_ff    (maker_id)
  );

  port_id_store #(.DFLT(PART_ID_DFLT)) u_part (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .load_en  (part_load),
    .load_val (part_val),
    .id_ff    (part_id)
  );

  // Byte lanes merge; only writable bits may change
  always_comb begin
    wr_data = {cfg_be[1] ? cfg_wdata[15:8] : cmd_ff[15:8],
               cfg_be[0] ? cfg_wdata[7:0] : cmd_ff[7:0]};
    nxt_cmd = cmd_ff;
    if (cfg_wr && cfg_addr == OFS_COMMAND) begin
      nxt_cmd = wr_data & CMD_WR_MASK;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_ff <= CMD_RESET;
    end else begin
      cmd_ff <= nxt_cmd;
    end
  end

  // Read mux; unmapped offsets return zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_addr == OFS_IDENT) begin
      cfg_rdata <= {part_id, maker_id};
    end else if (cfg_addr == OFS_COMMAND) begin
      cfg_rdata <= {16'h0000, cmd_ff & CMD_WR_MASK};
    end else begin
      cfg_rdata <= 32'h0000_0000;
    end
  end

  assign pri_io_accept  = pri_io_req & cmd_ff[CMD_IO_BIT];
  assign pri_mem_accept = pri_mem_req & cmd_ff[CMD_MEM_BIT];
  assign up_fwd = dn_req & cmd_ff[CMD_FWD_BIT];
  assign dn_ur  = dn_req & ~cmd_ff[CMD_FWD_BIT];
  assign ur_cpl = dn_ur & dn_nonposted;

  // Verdict encoding for the transaction layer
  always_comb begin
    case ({dn_req, cmd_ff[CMD_FWD_BIT]})
      2'b11:   dn_verdict = REQ_TAKE;
      2'b10:   dn_verdict = REQ_UR;
      default: dn_verdict = REQ_NONE;
    endcase
  end

  assign parity_act = parity_err & cmd_ff[CMD_PERR_BIT];
  assign err_msg = err_detect & cmd_ff[CMD_ERR_BIT];
  // own interrupts gated, forwarded pass always
  assign intx_msg = (own_intx & ~cmd_ff[CMD_INTD_BIT]) | fwd_intx;

  // sticky status; a new message wins over the clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sse_ff <= 1'b0;
    end else if (err_msg) begin
      sse_ff <= 1'b1;
    end else if (sse_clear) begin
      sse_ff <= 1'b0;
    end
  end

  chk_hardwired_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    (cmd_ff & ~CMD_WR_MASK) == 16'h0000) else $error("hardwired bit set");
  chk_cmd_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (cfg_wr && cfg_addr == OFS_COMMAND && cfg_be[0]) |=>
    cmd_ff[CMD_IO_BIT] == $past(cfg_wdata[CMD_IO_BIT])) else $error("io bit not written");
  chk_mem_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    pri_mem_accept |-> pri_mem_req && cmd_ff[CMD_MEM_BIT]) else $error("mem gate");
  chk_fwd_ur: assert property (@(posedge mclk) disable iff (!reset_n)
    dn_req |-> (up_fwd ^ dn_ur)) else $error("forward and reject clash");
  chk_ur_cpl: assert property (@(posedge mclk) disable iff (!reset_n)
    (dn_req && dn_nonposted && !cmd_ff[CMD_FWD_BIT]) |-> ur_cpl) else $error("no ur cpl");
  chk_fwd_on: assert property (@(posedge mclk) disable iff (!reset_n)
    (dn_req && cmd_ff[CMD_FWD_BIT]) |-> up_fwd && !ur_cpl) else $error("no forward");
  chk_err_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    err_msg |-> cmd_ff[CMD_ERR_BIT]) else $error("error reported while off");
  chk_intx_fwd: assert property (@(posedge mclk) disable iff (!reset_n)
    fwd_intx |-> intx_msg) else $error("forwarded intx blocked");
  chk_sse_set: assert property (@(posedge mclk) disable iff (!reset_n)
    err_msg |=> sse_ff) else $error("status not set");
  chk_parity_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    (parity_err && cmd_ff[CMD_PERR_BIT]) |-> parity_act) else $error("parity");

  // Read of the command offset, one cycle; the property checks the answer one edge later
  sequence cmd_read_seq;
    cfg_addr == OFS_COMMAND;
  endsequence

  // Read of the identification offset
  sequence ident_read_seq;
    cfg_addr == OFS_IDENT;
  endsequence

  // Reserved upper half never leaks onto the read bus
  chk_cmd_read: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd_read_seq |=> cfg_rdata[31:16] == 16'h0000) else $error("reserved bits read");
  // Identification read returns the stored values of the previous edge
  chk_ident_read: assert property (@(posedge mclk) disable iff (!reset_n)
    ident_read_seq |=> cfg_rdata == {$past(part_id), $past(maker_id)})
    else $error("identification read wrong");
  // Only a command write may move the enables
  chk_cmd_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    !(cfg_wr && cfg_addr == OFS_COMMAND) |=> $stable(cmd_ff))
    else $error("command changed without write");
  // I/O responses only while enabled
  chk_io_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    pri_io_accept |-> cmd_ff[CMD_IO_BIT]) else $error("io gate");
  // Posted rejects never produce a completion
  chk_ur_posted: assert property (@(posedge mclk) disable iff (!reset_n)
    (dn_req && !dn_nonposted) |-> !ur_cpl) else $error("completion for posted");
  // Own interrupts are held back while disabled
  chk_intx_own: assert property (@(posedge mclk) disable iff (!reset_n)
    (own_intx && !fwd_intx && cmd_ff[CMD_INTD_BIT]) |-> !intx_msg)
    else $error("own intx not blocked");
endmodule
`default_nettype wire

//--- verif/cfg_host.sv
// Configuration software model issuing register accesses
`timescale 1ns/1ns
`default_nettype none
module cfg_host (
  // Clock
  input  wire logic        mclk,
  // Configuration access
  output logic             cfg_wr,
  output logic      [7:0]  cfg_addr,
  output logic      [31:0] cfg_wdata,
  output logic      [3:0]  cfg_be,
  input  wire logic [31:0] cfg_rdata
);
  // Idle bus at time zero
  initial begin
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} = '0;
  end
  // Write held over one edge; data inverted after so a stale bus is never trusted
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] b);
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} = {1'h1, a, v, b};
    @(posedge mclk);
    #1 cfg_wr = 1'h0;
    cfg_wdata = ~v;
  endtask
  // Read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    cfg_addr = a;
    @(posedge mclk);
    #1 v = cfg_rdata;
  endtask
endmodule
`default_nettype wire

//--- verif/switch_port_id_and_command_regs_bench.sv
// Self-checking bench for the port identification and command registers
`timescale 1ns/1ns
`default_nettype none
module switch_port_id_and_command_regs_bench;
  import port_cfg_pkg::*;
  logic mclk, reset_n, cfg_wr, maker_load, part_load, pri_io_req, pri_mem_req, dn_req;
  logic dn_nonposted, parity_err, err_detect, sse_clear, own_intx, fwd_intx, sm;
  logic pri_io_accept, pri_mem_accept, up_fwd, dn_ur, ur_cpl, parity_act, err_msg, sse_ff;
  logic intx_msg;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [15:0] maker_val, part_val, m, mk, pt;
  logic [31:0] cfg_wdata, cfg_rdata, d;
  req_verdict_t dn_verdict;
  int bad_count, tests_run;
  integer seed;
  cfg_host i_cfg_host (.*);
  port_cmd_regs i_port_cmd_regs (.*);
  // Clock, 40 ns period
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  // Reference model; status update uses the command value from before the edge
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {m, sm, mk, pt} = {16'h0, 1'h0, MAKER_ID_DFLT, PART_ID_DFLT};
    end else begin
      sm = (sm & ~sse_clear) | (err_detect & m[8]);
      if (maker_load) mk = maker_val;
      if (part_load) pt = part_val;
      for (int i = 0; i < 2; i++)
        if (cfg_wr && cfg_addr == OFS_COMMAND && cfg_be[i])
          m[i*8+:8] = cfg_wdata[i*8+:8] & CMD_WR_MASK[i*8+:8];
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    tests_run++;
    if (e !== g) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Random traffic on every gate, then compare each gated output
  task automatic gates();
    {pri_io_req, pri_mem_req, dn_req, dn_nonposted, parity_err, err_detect, sse_clear,
     own_intx, fwd_intx} = 9'($random(seed));
    #1;
    chk(pri_io_req & m[0], pri_io_accept, "io_accept");
    chk(pri_mem_req & m[1], pri_mem_accept, "mem_accept");
    chk(dn_req & m[2], up_fwd, "up_fwd");
    chk(dn_req & ~m[2], dn_ur, "dn_ur");
    chk(dn_req & ~m[2] & dn_nonposted, ur_cpl, "ur_cpl");
    chk(!dn_req ? REQ_NONE : m[2] ? REQ_TAKE : REQ_UR, dn_verdict, "verdict");
    chk(parity_err & m[6], parity_act, "parity_act");
    chk(err_detect & m[8], err_msg, "err_msg");
    chk((own_intx & ~m[10]) | fwd_intx, intx_msg, "intx_msg");
    chk(sm, sse_ff, "sse");
  endtask
  // Hang guard
  initial begin
    #1000000;
    bad_count++;
    end_sim();
  end
  initial begin
    seed = 32'hb6514257;
    {reset_n, maker_load, part_load, maker_val, part_val} = '0;
    {pri_io_req, pri_mem_req, dn_req, dn_nonposted, parity_err, err_detect, sse_clear,
     own_intx, fwd_intx} = '0;
    repeat (8) @(posedge mclk);
    #1 reset_n = 1'h1;
    i_cfg_host.rd(OFS_COMMAND, d);
    chk(32'h0, d, "cmd_reset");
    i_cfg_host.rd(OFS_IDENT, d);
    chk({PART_ID_DFLT, MAKER_ID_DFLT}, d, "ids_reset");
    $display("test reset values done");
    i_cfg_host.wr(OFS_IDENT, $random(seed), 4'hf);
    i_cfg_host.rd(OFS_IDENT, d);
    chk({pt, mk}, d, "ids_write");
    i_cfg_host.rd(8'h08, d);
    chk(32'h0, d, "unmapped");
    i_cfg_host.wr(OFS_COMMAND, 32'hffffffff, 4'hf);
    i_cfg_host.rd(OFS_COMMAND, d);
    chk(32'h0547, d, "cmd_ones");
    $display("test refused writes done");
    repeat (60) begin
      i_cfg_host.wr(OFS_COMMAND, $random(seed), 4'($random(seed)));
      gates();
      i_cfg_host.rd(OFS_COMMAND, d);
      chk({16'h0, m}, d, "cmd_read");
      gates();
    end
    $display("test command gating done");
    {maker_val, part_val, maker_load, part_load} = {32'($random(seed)), 2'h3};
    @(posedge mclk);
    #1 {maker_load, part_load} = 2'h0;
    i_cfg_host.rd(OFS_IDENT, d);
    chk({pt, mk}, d, "ids_load");
    $display("test identification load done");
    end_sim();
  end
endmodule
`default_nettype wire
